/* File: pkg/async_serial_params.svh */
// Offsets, field positions, reset values and timing counts of the serial unit.
// Assumes it is included once by bare name from each of the two modules.
`ifndef ASYNC_SERIAL_PARAMS_SVH
`define ASYNC_SERIAL_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFF_IRQ_ENABLES 3'h0
`define OFF_IRQ_FLAGS 3'h1
`define OFF_RX_CTRL 3'h2
`define OFF_BAUD_DIV 3'h3
`define OFF_TX_HOLD 3'h4
`define OFF_TX_CTRL 3'h5
`define OFF_RX_DATA 3'h6
`define OFF_IRQ_CTRL 3'h7

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_RX_IRQ 5
`define BIT_TX_IRQ 4
`define BIT_GLOBAL_IE 7
`define BIT_PERIPH_IE 6
`define BIT_CLK_SRC 7
`define BIT_TX_NINE 6
`define BIT_TX_EN 5
`define BIT_SYNC 4
`define BIT_HIGH_SPEED 2
`define BIT_SHIFT_EMPTY 1
`define BIT_TX_NINTH 0
`define BIT_PORT_EN 7
`define BIT_RX_NINE 6
`define BIT_RX_CONT 4
`define BIT_FRAME_ERR 2
`define BIT_OVERRUN 1
`define BIT_RX_NINTH 0

// ----------------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_TX_CTRL 8'h02
`define TICKS_PER_BIT 5'h10
`define TICKS_HALF_BIT 5'h08
`define LOW_SPEED_PRESCALE 2'h3

`endif

/* File: pkg/async_serial_pkg.sv */
// Types shared by the serial unit and its baud tick generator.
// Assumes the parameter header is on the include path.
package async_serial_pkg;

    // One received character with its framing error status.
    typedef struct packed {
        logic frame_err;
        logic [8:0] data;
    } rx_entry_t;

    // Transmit shifter states.
    typedef enum logic [0:0] {
        TX_IDLE,
        TX_SHIFT
    } tx_state_t;

    // Receive data recovery states.
    typedef enum logic [1:0] {
        RX_HUNT,
        RX_START,
        RX_DATA,
        RX_STOP
    } rx_state_t;

endpackage : async_serial_pkg

/* File: hw/baud_tick_gen.sv */
// Sixteen-times baud tick generator for the serial unit.
// Assumes a synchronously released active-low reset copy from the parent.
`timescale 1ns/1ps
`include "async_serial_params.svh"

module baud_tick_gen
    import async_serial_pkg::*;
#(
    parameter int DIV_W = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_enable,
    input wire logic i_high_speed,
    input wire logic [DIV_W-1:0] i_divisor,
    output logic o_tick
);

    logic [DIV_W-1:0] cnt_reg;
    logic [1:0] pre_reg;
    logic tick_reg;
    wire cnt_zero = (cnt_reg == '0);
    wire pre_done = i_high_speed || (pre_reg == `LOW_SPEED_PRESCALE);

    // Divide by divisor plus one, then by four more in low-speed mode.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_reg <= '0;
            pre_reg <= 2'h0;
            tick_reg <= 1'b0;
        end else if (!i_enable) begin
            cnt_reg <= '0;
            pre_reg <= 2'h0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_zero ? i_divisor : cnt_reg - 1'b1;
            if (cnt_zero) begin
                pre_reg <= pre_done ? 2'h0 : pre_reg + 2'h1;
            end
            tick_reg <= cnt_zero && pre_done;
        end
    end

    assign o_tick = tick_reg;

endmodule : baud_tick_gen

/* File: hw/async_serial_tx_rx.sv */
// Asynchronous transmitter and receiver of the addressable serial unit.
// Assumes a register master with one-cycle strobes and pins synchronous
// to i_clk; the ninth receive bit and queue are read before the data.
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "async_serial_params.svh"

module async_serial_tx_rx
    import async_serial_pkg::*;
#(
    parameter int DIV_W = 8
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rd_data,
    input wire logic i_rx_pin,
    input wire logic i_gpio_rx_out,
    input wire logic i_gpio_rx_dir_n,
    input wire logic i_gpio_tx_out,
    input wire logic i_gpio_tx_dir_n,
    output logic o_rx_pin_out,
    output logic o_rx_pin_oe_n,
    output logic o_tx_pin_out,
    output logic o_tx_pin_oe_n,
    output logic o_tx_irq,
    output logic o_rx_irq
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_n;

    // Release the asynchronous reset through two flip-flops.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    logic [7:0] irq_en_reg;
    logic [7:0] irq_ctrl_reg;
    logic [7:0] tx_ctrl_reg;
    logic [7:0] rx_ctrl_reg;
    logic [7:0] baud_div_reg;
    logic tx_flag_reg;
    logic shift_empty_reg;
    logic overrun_reg;

    wire wr_irq_en = i_wr && (i_addr == `OFF_IRQ_ENABLES);
    wire wr_irq_ctrl = i_wr && (i_addr == `OFF_IRQ_CTRL);
    wire wr_tx_ctrl = i_wr && (i_addr == `OFF_TX_CTRL);
    wire wr_rx_ctrl = i_wr && (i_addr == `OFF_RX_CTRL);
    wire wr_baud = i_wr && (i_addr == `OFF_BAUD_DIV);
    wire wr_hold = i_wr && (i_addr == `OFF_TX_HOLD);
    wire rd_data = i_rd && (i_addr == `OFF_RX_DATA);

    wire port_en = rx_ctrl_reg[`BIT_PORT_EN];
    wire sync_mode = tx_ctrl_reg[`BIT_SYNC];
    wire tx_en = tx_ctrl_reg[`BIT_TX_EN] && port_en && !sync_mode;
    wire rx_en = rx_ctrl_reg[`BIT_RX_CONT] && !sync_mode && port_en;

    // Writable control registers; status bits are masked out on writes.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_en_reg <= `RST_BYTE;
            irq_ctrl_reg <= `RST_BYTE;
            tx_ctrl_reg <= `RST_BYTE;
            rx_ctrl_reg <= `RST_BYTE;
            baud_div_reg <= `RST_BYTE;
        end else begin
            if (wr_irq_en) irq_en_reg <= i_wr_data;
            if (wr_irq_ctrl) irq_ctrl_reg <= i_wr_data;
            if (wr_tx_ctrl) tx_ctrl_reg <= i_wr_data & 8'hf5;
            if (wr_rx_ctrl) rx_ctrl_reg <= i_wr_data & 8'hd0;
            if (wr_baud) baud_div_reg <= i_wr_data;
        end
    end

    // ------------------------------------------------------------------
    // Baud tick
    // ------------------------------------------------------------------
    logic tick;

    // One shared sixteen-times tick paces both directions.
    baud_tick_gen #(
        .DIV_W(DIV_W)
    ) u_baud (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_enable(port_en),
        .i_high_speed(tx_ctrl_reg[`BIT_HIGH_SPEED]),
        .i_divisor(baud_div_reg[DIV_W-1:0]),
        .o_tick(tick)
    );

    // ------------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------------
    tx_state_t tx_state_reg;
    logic [10:0] tx_shift_reg;
    logic [3:0] tx_bits_reg;
    logic [4:0] tx_ticks_reg;
    logic [8:0] hold_data_reg;
    logic hold_full_reg;
    logic tx_line_reg;

    wire tx_nine = tx_ctrl_reg[`BIT_TX_NINE];
    wire [8:0] wr_char = {tx_ctrl_reg[`BIT_TX_NINTH], i_wr_data};
    wire bit_done = tick && (tx_ticks_reg == `TICKS_PER_BIT - 5'h1);
    wire frame_done = bit_done && (tx_bits_reg == 4'h1);
    wire shifter_free = (tx_state_reg == TX_IDLE) || frame_done;
    wire load_now = tx_en && wr_hold && shifter_free && !hold_full_reg;
    wire load_held = tx_en && hold_full_reg && shifter_free;
    wire [8:0] load_char = load_held ? hold_data_reg : wr_char;
    wire load_go = load_now || load_held;
    // Stop, optional ninth bit, data, start; shifted out from bit zero.
    wire [10:0] load_frame = tx_nine ? {1'b1, load_char, 1'b0}
                                     : {2'b11, load_char[7:0], 1'b0};
    wire [3:0] load_bits = tx_nine ? 4'hb : 4'ha;

    // Holding register: a write lands here while the shifter is busy and this register is empty, or as the held character moves into it.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_data_reg <= 9'h000;
            hold_full_reg <= 1'b0;
        end else if (!tx_en) begin
            hold_full_reg <= 1'b0;
        end else if (wr_hold && !load_now && !(hold_full_reg && !load_held)) begin
            hold_data_reg <= wr_char;
            hold_full_reg <= 1'b1;
        end else if (load_held) begin
            hold_full_reg <= 1'b0;
        end
    end

    // Shifter state, bit and tick counters.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_state_reg <= TX_IDLE;
            tx_shift_reg <= 11'h7ff;
            tx_bits_reg <= 4'h0;
            tx_ticks_reg <= 5'h00;
        end else if (!tx_en) begin
            tx_state_reg <= TX_IDLE;
            tx_shift_reg <= 11'h7ff;
        end else if (load_go) begin
            tx_state_reg <= TX_SHIFT;
            tx_shift_reg <= load_frame;
            tx_bits_reg <= load_bits;
            tx_ticks_reg <= 5'h00;
        end else begin
            case (tx_state_reg)
                TX_IDLE: begin
                    tx_ticks_reg <= 5'h00;
                end
                TX_SHIFT: begin
                    if (frame_done) begin
                        tx_state_reg <= TX_IDLE;
                    end else if (bit_done) begin
                        tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
                        tx_bits_reg <= tx_bits_reg - 4'h1;
                        tx_ticks_reg <= 5'h00;
                    end else if (tick) begin
                        tx_ticks_reg <= tx_ticks_reg + 5'h01;
                    end
                end
                default: begin
                    tx_state_reg <= TX_IDLE;
                end
            endcase
        end
    end

    // Line level, shift-empty status and the buffer-empty flag.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_line_reg <= 1'b1;
            shift_empty_reg <= 1'b1;
            tx_flag_reg <= 1'b0;
        end else begin
            tx_line_reg <= (tx_state_reg == TX_SHIFT) ? tx_shift_reg[0]
                                                      : 1'b1;
            shift_empty_reg <= (tx_state_reg == TX_IDLE);
            tx_flag_reg <= tx_en && !hold_full_reg;
        end
    end

    // ------------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------------
    rx_state_t rx_state_reg;
    logic [2:0] rx_win_reg;
    logic rx_prev_reg;
    logic [4:0] rx_ticks_reg;
    logic [3:0] rx_bits_reg;
    logic [8:0] rx_shift_reg;
    rx_entry_t fifo_reg [2];
    logic fifo_head_reg;
    logic [1:0] fifo_count_reg;

    wire rx_line = port_en ? i_rx_pin : 1'b1;
    wire rx_nine = rx_ctrl_reg[`BIT_RX_NINE];
    // Two of three recent tick samples decide the bit.
    wire rx_vote = (rx_win_reg[0] & rx_win_reg[1]) |
                   (rx_win_reg[1] & rx_win_reg[2]) |
                   (rx_win_reg[0] & rx_win_reg[2]);
    wire rx_fall = tick && rx_prev_reg && !rx_line;
    wire at_half = tick && (rx_ticks_reg == `TICKS_HALF_BIT - 5'h1);
    wire at_full = tick && (rx_ticks_reg == `TICKS_PER_BIT - 5'h1);
    wire [8:0] rx_char = rx_nine ? rx_shift_reg : {1'b0, rx_shift_reg[8:1]};
    wire rx_done = (rx_state_reg == RX_STOP) && at_full;
    wire fifo_full = (fifo_count_reg == 2'h2);
    wire pop = rd_data && (fifo_count_reg != 2'h0);
    wire push = rx_done && rx_en && !fifo_full && !overrun_reg;
    wire over_hit = rx_done && rx_en && fifo_full;
    wire fifo_tail = fifo_head_reg ^ fifo_count_reg[0];
    rx_entry_t top;
    rx_entry_t new_entry;

    assign top = fifo_reg[fifo_head_reg];
    assign new_entry = '{frame_err: !rx_vote, data: rx_char};

    // Data recovery: tick window, edge hunt, centre sampling.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_state_reg <= RX_HUNT;
            rx_win_reg <= 3'h7;
            rx_prev_reg <= 1'b1;
            rx_ticks_reg <= 5'h00;
            rx_bits_reg <= 4'h0;
            rx_shift_reg <= 9'h000;
        end else if (!rx_en) begin
            rx_state_reg <= RX_HUNT;
            rx_prev_reg <= 1'b1;
        end else begin
            if (tick) begin
                rx_win_reg <= {rx_win_reg[1:0], rx_line};
                rx_prev_reg <= rx_line;
                rx_ticks_reg <= rx_ticks_reg + 5'h01;
            end
            case (rx_state_reg)
                RX_HUNT: begin
                    if (rx_fall && !overrun_reg) begin
                        rx_state_reg <= RX_START;
                        rx_ticks_reg <= 5'h00;
                    end
                end
                RX_START: begin
                    if (at_half) begin
                        rx_ticks_reg <= 5'h00;
                        rx_bits_reg <= rx_nine ? 4'h9 : 4'h8;
                        rx_state_reg <= rx_vote ? RX_HUNT : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (at_full) begin
                        rx_ticks_reg <= 5'h00;
                        rx_shift_reg <= {rx_vote, rx_shift_reg[8:1]};
                        rx_bits_reg <= rx_bits_reg - 4'h1;
                        if (rx_bits_reg == 4'h1) rx_state_reg <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (at_full) rx_state_reg <= RX_HUNT;
                end
                default: begin
                    rx_state_reg <= RX_HUNT;
                end
            endcase
        end
    end

    // Two-entry queue of stored characters, one cell per entry.
    generate
        for (genvar i = 0; i < 2; i++) begin : g_fifo
            always_ff @(posedge i_clk or negedge rst_n) begin
                if (!rst_n) begin
                    fifo_reg[i] <= '0;
                end else if (push && (fifo_tail == 1'(i))) begin
                    fifo_reg[i] <= new_entry;
                end
            end
        end
    endgenerate

    // Queue pointers and overrun status; a clear of port or receiver wins.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            fifo_head_reg <= 1'b0;
            fifo_count_reg <= 2'h0;
            overrun_reg <= 1'b0;
        end else if (!port_en) begin
            fifo_head_reg <= 1'b0;
            fifo_count_reg <= 2'h0;
            overrun_reg <= 1'b0;
        end else begin
            if (pop) fifo_head_reg <= !fifo_head_reg;
            fifo_count_reg <= fifo_count_reg + {1'b0, push}
                              - {1'b0, pop};
            if (!rx_ctrl_reg[`BIT_RX_CONT]) begin
                overrun_reg <= 1'b0;
            end else if (over_hit) begin
                overrun_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read-back, flags and interrupt requests
    // ------------------------------------------------------------------
    wire rx_flag = rx_en && (fifo_count_reg != 2'h0);
    wire irq_gate = irq_ctrl_reg[`BIT_GLOBAL_IE] && irq_ctrl_reg[`BIT_PERIPH_IE];
    wire [7:0] flags_view = {2'b00, rx_flag, tx_flag_reg, 4'h0};
    wire [7:0] tx_ctrl_view = (tx_ctrl_reg & 8'hf5) |
                              {6'h00, shift_empty_reg, 1'b0};
    wire [7:0] rx_ctrl_view = (rx_ctrl_reg & 8'hd0) |
                              {5'h00, top.frame_err && rx_flag,
                               overrun_reg, top.data[8] && rx_flag};
    wire [7:0] rd_mux =
        (i_addr == `OFF_IRQ_ENABLES) ? irq_en_reg :
        (i_addr == `OFF_IRQ_FLAGS) ? flags_view :
        (i_addr == `OFF_RX_CTRL) ? rx_ctrl_view :
        (i_addr == `OFF_BAUD_DIV) ? baud_div_reg :
        (i_addr == `OFF_TX_CTRL) ? tx_ctrl_view :
        (i_addr == `OFF_RX_DATA) ? (rx_flag ? top.data[7:0] : 8'h00) :
        (i_addr == `OFF_IRQ_CTRL) ? irq_ctrl_reg : 8'h00;

    logic [7:0] rd_data_reg;
    logic tx_irq_reg;
    logic rx_irq_reg;

    // Read data in the cycle after the strobe; interrupt requests.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_reg <= 8'h00;
            tx_irq_reg <= 1'b0;
            rx_irq_reg <= 1'b0;
        end else begin
            rd_data_reg <= i_rd ? rd_mux : 8'h00;
            tx_irq_reg <= irq_gate && irq_en_reg[`BIT_TX_IRQ]
                          && tx_flag_reg;
            rx_irq_reg <= irq_gate && irq_en_reg[`BIT_RX_IRQ]
                          && rx_flag;
        end
    end

    // ------------------------------------------------------------------
    // Pin control
    // ------------------------------------------------------------------
    logic tx_pin_reg;
    logic tx_oe_n_reg;
    logic rx_pin_reg;
    logic rx_oe_n_reg;

    // Port enable takes the pins away from the general-purpose port.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_pin_reg <= 1'b1;
            tx_oe_n_reg <= 1'b1;
            rx_pin_reg <= 1'b1;
            rx_oe_n_reg <= 1'b1;
        end else begin
            tx_pin_reg <= port_en ? tx_line_reg : i_gpio_tx_out;
            tx_oe_n_reg <= port_en ? 1'b0 : i_gpio_tx_dir_n;
            rx_pin_reg <= i_gpio_rx_out;
            rx_oe_n_reg <= port_en ? 1'b1 : i_gpio_rx_dir_n;
        end
    end

    assign o_rd_data = rd_data_reg;
    assign o_tx_pin_out = tx_pin_reg;
    assign o_tx_pin_oe_n = tx_oe_n_reg;
    assign o_rx_pin_out = rx_pin_reg;
    assign o_rx_pin_oe_n = rx_oe_n_reg;
    assign o_tx_irq = tx_irq_reg;
    assign o_rx_irq = rx_irq_reg;

endmodule : async_serial_tx_rx

/* File: bench/async_serial_tx_rx_assertions.sv */
// Port checker of the serial unit; shadows the written control bits.
// Assumes control bits change only through register writes.
`timescale 1ns/1ps
module serial_checker (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rd_data,
    input wire logic o_rx_pin_oe_n,
    input wire logic o_tx_pin_oe_n,
    input wire logic o_tx_irq,
    input wire logic o_rx_irq
);
    logic [7:0] sh_reg [0:7];
    // Keeps a copy of every register as last written.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) sh_reg <= '{default: 8'h00};
        else if (i_wr) sh_reg[i_addr] <= i_wr_data;
    end
    // Enables decoded from the copies.
    wire pe = sh_reg[2][7];
    wire tx_off = !sh_reg[5][5];
    wire rx_off = !sh_reg[2][4];
    wire ie = sh_reg[7][7] && sh_reg[7][6];
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    property p_tx_oe; $past(pe) |-> !o_tx_pin_oe_n; endproperty
    a_tx_oe: assert property (p_tx_oe) else $error("tx oe");
    property p_rx_oe; $past(pe) |-> o_rx_pin_oe_n; endproperty
    a_rx_oe: assert property (p_rx_oe) else $error("rx oe");
    property p_tx_irq; o_tx_irq |-> $past(ie && sh_reg[0][4]); endproperty
    a_tx_irq: assert property (p_tx_irq) else $error("tx irq");
    property p_rx_irq; o_rx_irq |-> $past(ie && sh_reg[0][5]); endproperty
    a_rx_irq: assert property (p_rx_irq) else $error("rx irq");
    property p_rx_quiet;
        rx_off && $past(rx_off) && $past(rx_off, 2) |-> !o_rx_irq;
    endproperty
    a_rx_quiet: assert property (p_rx_quiet) else $error("rx on");
    property p_tx_flag;
        i_rd && i_addr == 3'h1 && tx_off && $past(tx_off) |=> !o_rd_data[4];
    endproperty
    a_tx_flag: assert property (p_tx_flag) else $error("tx flag");
    property p_rx_flag;
        i_rd && i_addr == 3'h1 && rx_off && $past(rx_off) |=> !o_rd_data[5];
    endproperty
    a_rx_flag: assert property (p_rx_flag) else $error("rx flag");
    property p_shift_idle;
        i_rd && i_addr == 3'h5 && tx_off && $past(tx_off, 2) |=> o_rd_data[1];
    endproperty
    a_shift_idle: assert property (p_shift_idle) else $error("shift");
endmodule : serial_checker

bind async_serial_tx_rx serial_checker u_chk (.i_clk, .i_resetn, .i_addr,
    .i_wr_data, .i_wr, .i_rd, .o_rd_data, .o_rx_pin_oe_n, .o_tx_pin_oe_n,
    .o_tx_irq, .o_rx_irq);

/* File: bench/serial_node.sv */
// Remote serial node driving the receive line of the serial unit.
// Assumes sixteen clock cycles per bit (divisor 0, high speed set).
`timescale 1ns/1ps
module serial_node (
    input wire logic i_clk,
    output logic o_line
);
    initial o_line = 1'b1;
    // Sends start, n data bits LSB first, a stop of level stp, then idle.
    task automatic send(input logic [8:0] d, input int n, input logic stp);
        for (int i = 0; i < n + 2; i++) begin
            @(posedge i_clk);
            o_line <= (i == 0) ? 1'b0 : (i > n) ? stp : d[i-1];
            repeat (15) @(posedge i_clk);
        end
        @(posedge i_clk);
        o_line <= 1'b1;
    endtask : send
    // Low pulse shorter than half a bit, so a false start.
    task automatic glitch();
        @(posedge i_clk);
        o_line <= 1'b0;
        repeat (4) @(posedge i_clk);
        o_line <= 1'b1;
    endtask : glitch
endmodule : serial_node

/* File: bench/testbench.sv */
// Self-checking bench of the serial unit with a queue model of reception.
// Assumes divisor 0 and high speed set, so each bit lasts 16 clocks.
`timescale 1ns/1ps
module testbench;
    logic i_clk = 1'b0, i_resetn = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic [2:0] i_addr = 3'h0;
    logic [7:0] i_wr_data = 8'h00, o_rd_data, b0, b1;
    logic rx_line, tx_out, txi, rxi, rxo, rxoe, txoe, ovr = 1'b0;
    logic [3:0] gp = 4'h0;
    logic [4:0] rc = 5'b10010;
    logic [8:0] c;
    logic [9:0] q[$];
    int n_fail = 0, num_checks = 0, seed = 43080;
    always #5 i_clk = ~i_clk;
    serial_node u_node (.i_clk, .o_line(rx_line));
    async_serial_tx_rx i_dut (.i_clk, .i_resetn, .i_addr, .i_wr_data, .i_wr,
        .i_rd, .o_rd_data, .i_rx_pin(rx_line), .i_gpio_rx_out(gp[3]),
        .i_gpio_rx_dir_n(gp[2]), .i_gpio_tx_out(gp[1]),
        .i_gpio_tx_dir_n(gp[0]), .o_rx_pin_out(rxo), .o_rx_pin_oe_n(rxoe),
        .o_tx_pin_out(tx_out), .o_tx_pin_oe_n(txoe), .o_tx_irq(txi),
        .o_rx_irq(rxi));
    task automatic conclude();
        if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    task automatic chk(input logic [8:0] g, input logic [8:0] e);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wr_data <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk({1'b0, o_rd_data}, {1'b0, e});
    endtask : rd
    // Expected receive control read; rc holds the enable bits as written.
    function automatic logic [7:0] rc_exp();
        return {rc, q.size() > 0 && q[0][9], ovr, q.size() > 0 && q[0][8]};
    endfunction : rc_exp
    // Sends one character and updates the model queue.
    task automatic rx_send(input logic [8:0] d, input logic stp);
        u_node.send(d, rc[3] ? 9 : 8, stp);
        if (!ovr && q.size() == 2) ovr = 1'b1;
        else if (!ovr) q.push_back({!stp, rc[3] & d[8], d[7:0]});
    endtask : rx_send
    // Reads status, then data of the oldest entry.
    task automatic rx_pop();
        logic [9:0] e;
        rd(3'h2, rc_exp());
        e = q.pop_front();
        rd(3'h6, e[7:0]);
    endtask : rx_pop
    // Captures one frame from the transmit pin at bit centres.
    task automatic tx_get(input int n, input int bound, output logic [8:0] d);
        int k;
        k = 0;
        d = 9'h000;
        while (tx_out !== 1'b0) begin
            @(posedge i_clk);
            k++;
            if (k > bound) begin
                n_fail++;
                conclude();
            end
        end
        repeat (8) @(posedge i_clk);
        chk({8'h00, tx_out}, 9'h000);
        for (int i = 0; i < n; i++) begin
            repeat (16) @(posedge i_clk);
            d[i] = tx_out;
        end
        repeat (16) @(posedge i_clk);
        chk({8'h00, tx_out}, 9'h001);
    endtask : tx_get
    initial begin
        repeat (12) @(posedge i_clk);
        i_resetn <= 1'b1;
        repeat (3) @(posedge i_clk);
        gp <= 4'($random(seed));
        for (int a = 0; a < 8; a++) rd(3'(a), (a == 5) ? 8'h02 : 8'h00);
        chk({5'h00, rxo, rxoe, tx_out, txoe}, {5'h00, gp});
        wr(3'h3, 8'h00);
        wr(3'h2, 8'h90);
        wr(3'h5, 8'h24);
        wr(3'h0, 8'h30);
        wr(3'h7, 8'hc0);
        rd(3'h1, 8'h10);
        chk({8'h00, txi}, 9'h001);
        chk({5'h00, rxo, rxoe, tx_out, txoe}, {5'h00, gp[3], 3'b110});
        wr(3'h1, 8'h20);
        rd(3'h1, 8'h10);
        b0 = 8'($random(seed));
        b1 = 8'($random(seed));
        fork
            begin
                tx_get(8, 40, c);
                chk(c, {1'b0, b0});
                tx_get(8, 12, c);
                chk(c, {1'b0, b1});
            end
            begin
                wr(3'h4, b0);
                wr(3'h4, b1);
                rd(3'h1, 8'h00);
                chk({8'h00, txi}, 9'h000);
                wr(3'h0, 8'h20);
                rd(3'h5, 8'h24);
            end
        join
        repeat (12) @(posedge i_clk);
        rd(3'h5, 8'h26);
        wr(3'h5, 8'h65);
        fork
            tx_get(9, 40, c);
            wr(3'h4, b0);
        join
        chk(c, {1'b1, b0});
        repeat (12) @(posedge i_clk);
        repeat (3) rx_send(9'($random(seed)), 1'b1);
        rd(3'h1, 8'h30);
        chk({8'h00, rxi}, 9'h001);
        rx_send(9'($random(seed)), 1'b1);
        repeat (2) rx_pop();
        rd(3'h1, 8'h10);
        wr(3'h2, 8'h80);
        ovr = 1'b0;
        wr(3'h2, 8'h90);
        u_node.glitch();
        repeat (200) @(posedge i_clk);
        rd(3'h1, 8'h10);
        rx_send(9'($random(seed)), 1'b0);
        rx_pop();
        rc = 5'b11010;
        wr(3'h2, 8'hd0);
        rx_send(9'($random(seed)), 1'b1);
        rx_pop();
        chk({8'h00, tx_out}, 9'h001);
        conclude();
    end
endmodule : testbench
